//--- rtl/ufl_ctrl.sv
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "ufl_params.svh"
module ufl_ctrl
  import ufl_pkg::*;
#(
  parameter int CW = 9
)
(
  input  wire logic          CLK,
  input  wire logic          ARST_N,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [11:0]   PADDR,
  input  wire logic [31:0]   PWDATA,
  input  wire logic          RX_PUSH,
  input  wire logic          RX_POP,
  input  wire logic          TX_PUSH,
  input  wire logic          TX_POP,
  input  wire logic          TX_SER,
  input  wire logic [5:0]    INT_SRC,
  output logic [31:0]        PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  output logic               IRQ,
  output logic               TXD,
  output logic               FIFO_EN,
  output logic               DMA_MODE,
  output logic               DIV_SEL,
  output logic [1:0]         DATA_BITS,
  output logic [1:0]         STOP_MODE,
  output logic [2:0]         PARITY_MODE,
  output logic               RX_INT,
  output logic               TX_INT
);
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic              acc;
  logic              done;
  logic              wr;
  logic              rd;
  logic              hit;
  logic              isr_rd;
  logic              evt_rd;
  assign acc  = PSEL & PENABLE;
  // Side effects wait for the completing edge; the access phase spans two edges
  assign done = acc & PREADY;
  assign wr   = done & PWRITE;
  assign rd   = done & ~PWRITE;
  assign isr_rd = rd & (PADDR == `UFL_ADDR_ISR_STAT);
  assign evt_rd = rd & (PADDR == `UFL_ADDR_EVT_STAT);
  always_comb
  begin
    if (PADDR == `UFL_ADDR_ISR_STAT) hit = 1'b1;
    else if (PADDR == `UFL_ADDR_FIFO_CTL) hit = 1'b1;
    else if (PADDR == `UFL_ADDR_LINE_CTL) hit = 1'b1;
    else if (PADDR == `UFL_ADDR_FEAT_CTL) hit = 1'b1;
    else if (PADDR == `UFL_ADDR_ENH_FUNC) hit = 1'b1;
    else if (PADDR == `UFL_ADDR_RX_LEVEL) hit = 1'b1;
    else if (PADDR == `UFL_ADDR_TX_LEVEL) hit = 1'b1;
    else if (PADDR == `UFL_ADDR_EVT_STAT) hit = 1'b1;
    else if (PADDR == `UFL_ADDR_EVT_MASK) hit = 1'b1;
    else if (PADDR == `UFL_ADDR_FIFO_CNT) hit = 1'b1;
    else hit = 1'b0;
  end
  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [7:0]        lc_q;
  logic [1:0]        tbl_q;
  logic [7:0]        enh_q;
  logic [7:0]        rxlvl_q;
  logic [7:0]        txlvl_q;
  logic              fen_q;
  logic              dma_q;
  logic [1:0]        rxsel_q;
  logic [1:0]        txsel_q;
  logic              rxrst_q;
  logic              txrst_q;
  logic [1:0]        mask_q;
  logic              fc_wr;
  logic [7:0]        wd;
  assign wd    = PWDATA[7:0];
  assign fc_wr = wr & (PADDR == `UFL_ADDR_FIFO_CTL);
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N) lc_q <= `UFL_LC_RST_VAL;
    else if (wr && PADDR == `UFL_ADDR_LINE_CTL) lc_q <= wd;
  end
  // Table select is shared, so receive and transmit never disagree
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N) tbl_q <= 2'h0;
    else if (wr && PADDR == `UFL_ADDR_FEAT_CTL) tbl_q <= wd[7:6];
  end
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N) enh_q <= 8'h00;
    else if (wr && PADDR == `UFL_ADDR_ENH_FUNC) enh_q <= wd;
  end
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rxlvl_q <= `UFL_LVL_RESET;
      txlvl_q <= `UFL_LVL_RESET;
    end
    else if (wr)
    begin
      if (PADDR == `UFL_ADDR_RX_LEVEL) rxlvl_q <= wd;
      else if (PADDR == `UFL_ADDR_TX_LEVEL) txlvl_q <= wd;
    end
  end
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N) mask_q <= 2'h0;
    else if (wr && PADDR == `UFL_ADDR_EVT_MASK) mask_q <= PWDATA[1:0];
  end
  // Write-only FIFO control kept as shadow copies
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      fen_q   <= 1'b0;
      dma_q   <= 1'b0;
      rxsel_q <= 2'h0;
      txsel_q <= 2'h0;
    end
    else if (fc_wr)
    begin
      fen_q <= wd[`UFL_FC_EN];
      if (wd[`UFL_FC_EN])
      begin
        dma_q   <= wd[`UFL_FC_DMA];
        rxsel_q <= wd[7:6];
        if (enh_q[`UFL_EF_ENH]) txsel_q <= wd[5:4];
      end
    end
  end
  // Reset strobes last one cycle; the register has no read path and reads back as zero
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rxrst_q <= 1'b0;
      txrst_q <= 1'b0;
    end
    else
    begin
      rxrst_q <= fc_wr & wd[`UFL_FC_EN] & wd[`UFL_FC_RXRST];
      txrst_q <= fc_wr & wd[`UFL_FC_EN] & wd[`UFL_FC_TXRST];
    end
  end
  // ----------------------------------------
  // Level counters
  // ----------------------------------------
  logic [CW-1:0]     rxcnt_q;
  logic [CW-1:0]     txcnt_q;
  // Counters stop at full; a push beyond that is lost, never wraps
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N) rxcnt_q <= '0;
    else if (rxrst_q || !fen_q) rxcnt_q <= '0;
    else if (RX_PUSH && !RX_POP && rxcnt_q != '1) rxcnt_q <= rxcnt_q + 1'b1;
    else if (RX_POP && !RX_PUSH && rxcnt_q != '0) rxcnt_q <= rxcnt_q - 1'b1;
  end
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N) txcnt_q <= '0;
    else if (txrst_q || !fen_q) txcnt_q <= '0;
    else if (TX_PUSH && !TX_POP && txcnt_q != '1) txcnt_q <= txcnt_q + 1'b1;
    else if (TX_POP && !TX_PUSH && txcnt_q != '0) txcnt_q <= txcnt_q - 1'b1;
  end
  // ----------------------------------------
  // Trigger tables
  // ----------------------------------------
  logic [7:0]        rxtrig;
  logic [7:0]        txtrig;
  always_comb
  begin
    rxtrig = rxlvl_q;
    txtrig = txlvl_q;
    case (tbl_q)
      2'd0:
      begin
        case (rxsel_q)
          2'd0: rxtrig = 8'h01;
          2'd1: rxtrig = 8'h04;
          2'd2: rxtrig = 8'h08;
          default: rxtrig = 8'h0E;
        endcase
        txtrig = 8'h01;
      end
      2'd1:
      begin
        case (rxsel_q)
          2'd0: rxtrig = 8'h08;
          2'd1: rxtrig = 8'h10;
          2'd2: rxtrig = 8'h18;
          default: rxtrig = 8'h1C;
        endcase
        case (txsel_q)
          2'd0: txtrig = 8'h10;
          2'd1: txtrig = 8'h08;
          2'd2: txtrig = 8'h18;
          default: txtrig = 8'h1E;
        endcase
      end
      2'd2:
      begin
        case (rxsel_q)
          2'd0: rxtrig = 8'h08;
          2'd1: rxtrig = 8'h10;
          2'd2: rxtrig = 8'h38;
          default: rxtrig = 8'h3C;
        endcase
        case (txsel_q)
          2'd0: txtrig = 8'h08;
          2'd1: txtrig = 8'h10;
          2'd2: txtrig = 8'h20;
          default: txtrig = 8'h38;
        endcase
      end
      default:
      begin
        rxtrig = rxlvl_q;
        txtrig = txlvl_q;
      end
    endcase
  end
  // ----------------------------------------
  // FIFO interrupts
  // ----------------------------------------
  logic              rx_lvl;
  logic              tx_below;
  logic              tx_prev_q;
  logic              tx_empty_prev_q;
  logic              tx_ev;
  logic              rx_ev;
  logic              rx_prev_q;
  logic              tx_pend_q;
  assign rx_lvl   = fen_q & ({{(16-CW){1'b0}}, rxcnt_q} >= {8'h00, rxtrig});
  assign tx_below = fen_q & ({{(16-CW){1'b0}}, txcnt_q} < {8'h00, txtrig});
  // Fires on the fall below the level, and again on reaching empty
  assign tx_ev = (tx_below & ~tx_prev_q) |
                 (fen_q & (txcnt_q == '0) & ~tx_empty_prev_q);
  assign rx_ev = rx_lvl & ~rx_prev_q;
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      tx_prev_q       <= 1'b1;
      tx_empty_prev_q <= 1'b1;
      rx_prev_q       <= 1'b0;
    end
    else
    begin
      tx_prev_q       <= tx_below;
      tx_empty_prev_q <= fen_q & (txcnt_q == '0);
      rx_prev_q       <= rx_lvl;
    end
  end
  // Set wins over a clear by status read or a transmit load
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N) tx_pend_q <= 1'b0;
    else if (tx_ev) tx_pend_q <= 1'b1;
    else if (TX_PUSH || isr_rd) tx_pend_q <= 1'b0;
  end
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      RX_INT <= 1'b0;
      TX_INT <= 1'b0;
    end
    else
    begin
      RX_INT <= rx_lvl;
      TX_INT <= tx_ev | tx_pend_q;
    end
  end
  // ----------------------------------------
  // Event status with mask, cleared on read
  // ----------------------------------------
  logic [1:0]        evt_q;
  logic [1:0]        evt_set;
  assign evt_set = {tx_ev, rx_ev};
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N) evt_q <= 2'h0;
    else if (evt_rd) evt_q <= evt_set;
    else evt_q <= evt_q | evt_set;
  end
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N) IRQ <= 1'b0;
    else IRQ <= |((evt_q | evt_set) & mask_q);
  end
  // ----------------------------------------
  // Line format outputs
  // ----------------------------------------
  ufl_parity_t       par;
  ufl_stop_t         stp;
  always_comb
  begin
    if (!lc_q[3]) par = UFL_PAR_NONE;
    else if (!lc_q[5]) par = lc_q[4] ? UFL_PAR_EVEN : UFL_PAR_ODD;
    else par = lc_q[4] ? UFL_PAR_SPACE : UFL_PAR_MARK;
    if (!lc_q[2]) stp = UFL_STOP_1;
    else if (lc_q[1:0] == 2'b00) stp = UFL_STOP_1P5;
    else stp = UFL_STOP_2;
  end
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      TXD         <= 1'b1;
      FIFO_EN     <= 1'b0;
      DMA_MODE    <= 1'b0;
      DIV_SEL     <= 1'b0;
      DATA_BITS   <= 2'h0;
      STOP_MODE   <= 2'h0;
      PARITY_MODE <= 3'h0;
    end
    else
    begin
      TXD         <= TX_SER & ~lc_q[`UFL_LC_BREAK];
      FIFO_EN     <= fen_q;
      DMA_MODE    <= dma_q;
      DIV_SEL     <= lc_q[`UFL_LC_DIVSEL];
      DATA_BITS   <= lc_q[1:0];
      STOP_MODE   <= stp;
      PARITY_MODE <= par;
    end
  end
  // ----------------------------------------
  // Read data, one wait state
  // ----------------------------------------
  logic [7:0]        interrupt_status;
  logic [31:0]       rdat;
  // Pending source code from the priority logic outside; bit 0 low means pending
  assign interrupt_status = {fen_q, fen_q, INT_SRC[5:1], ~|INT_SRC};
  always_comb
  begin
    rdat = 32'h0000_0000;
    if (PADDR == `UFL_ADDR_ISR_STAT) rdat = {24'h00_0000, interrupt_status};
    else if (PADDR == `UFL_ADDR_LINE_CTL) rdat = {24'h00_0000, lc_q};
    else if (PADDR == `UFL_ADDR_FEAT_CTL) rdat = {24'h00_0000, tbl_q, 6'h00};
    else if (PADDR == `UFL_ADDR_ENH_FUNC) rdat = {24'h00_0000, enh_q};
    else if (PADDR == `UFL_ADDR_RX_LEVEL) rdat = {24'h00_0000, rxlvl_q};
    else if (PADDR == `UFL_ADDR_TX_LEVEL) rdat = {24'h00_0000, txlvl_q};
    // Same-cycle sets are returned too, so the clear never drops an event
    else if (PADDR == `UFL_ADDR_EVT_STAT) rdat = {30'h0000_0000, evt_q | evt_set};
    else if (PADDR == `UFL_ADDR_EVT_MASK) rdat = {30'h0000_0000, mask_q};
    else if (PADDR == `UFL_ADDR_FIFO_CNT)
      rdat = {{(16-CW){1'b0}}, txcnt_q, {(16-CW){1'b0}}, rxcnt_q};
  end
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PRDATA  <= rdat;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~hit;
    end
  end
endmodule

//--- rtl/ufl_params.svh
`ifndef UFL_PARAMS_SVH
`define UFL_PARAMS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define UFL_ADDR_ISR_STAT   12'h000
`define UFL_ADDR_FIFO_CTL   12'h004
`define UFL_ADDR_LINE_CTL   12'h008
`define UFL_ADDR_FEAT_CTL   12'h00C
`define UFL_ADDR_ENH_FUNC   12'h010
`define UFL_ADDR_RX_LEVEL   12'h014
`define UFL_ADDR_TX_LEVEL   12'h018
`define UFL_ADDR_EVT_STAT   12'h01C
`define UFL_ADDR_EVT_MASK   12'h020
`define UFL_ADDR_FIFO_CNT   12'h024
// ----------------------------------------
// Field positions and resets
// ----------------------------------------
`define UFL_FC_EN           0
`define UFL_FC_RXRST        1
`define UFL_FC_TXRST        2
`define UFL_FC_DMA          3
`define UFL_EF_ENH          4
`define UFL_LC_DIVSEL       7
`define UFL_LC_BREAK        6
`define UFL_LC_RESET        8'h03
`define UFL_LC_RST_VAL      8'h00
`define UFL_LVL_RESET       8'h01
`endif

//--- rtl/ufl_pkg.sv
package ufl_pkg;
  typedef enum logic [2:0] {UFL_PAR_NONE, UFL_PAR_ODD, UFL_PAR_EVEN,
                            UFL_PAR_MARK, UFL_PAR_SPACE} ufl_parity_t;
  typedef enum logic [1:0] {UFL_STOP_1, UFL_STOP_1P5, UFL_STOP_2} ufl_stop_t;
endpackage

//--- sim/tb_uart_fifo_and_line_control.sv
`timescale 1ns/1ns
`include "ufl_params.svh"
module tb_uart_fifo_and_line_control;
  localparam logic [11:0] a_lc = `UFL_ADDR_LINE_CTL;
  localparam logic [11:0] a_fc = `UFL_ADDR_FIFO_CTL;
  localparam logic [11:0] a_ft = `UFL_ADDR_FEAT_CTL;
  localparam logic [11:0] a_ct = `UFL_ADDR_FIFO_CNT;
  logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, tx_ser = 1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0]  ev = '0;
  logic [5:0]  int_src = '0;
  logic        pready, pslverr, irq, txd, fifo_en, dma_mode, div_sel, rx_int, err, tx_int;
  logic [1:0]  data_bits, stop_mode;
  logic [2:0]  parity_mode;
  int          errors = 0, num_checks = 0, cyc = 0;

  always #50 clk = ~clk;

  ufl_ctrl #(.CW(9)) dut (
    .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .RX_PUSH(ev[0]), .RX_POP(ev[1]), .TX_PUSH(ev[2]),
    .TX_POP(ev[3]), .TX_SER(tx_ser), .INT_SRC(int_src), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .TXD(txd), .FIFO_EN(fifo_en), .DMA_MODE(dma_mode),
    .DIV_SEL(div_sel), .DATA_BITS(data_bits), .STOP_MODE(stop_mode),
    .PARITY_MODE(parity_mode), .RX_INT(rx_int), .TX_INT(tx_int)
  );

  // ----------------------------------------
  // Bus and helpers
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // Waits on pready; only the cycle ceiling ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input logic [3:0] m, input int n);
    repeat (n)
    begin
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 4'h0;
    end
    repeat (3) @(posedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(txd === 1'b1 && fifo_en === 1'b0 && div_sel === 1'b0, "reset pins");
    chk(data_bits === 2'h0 && parity_mode === 3'h0, "reset format");
    apb(0, a_lc, 32'h0);
    chk(rd === 32'h0, "line reset");
    apb(0, `UFL_ADDR_ISR_STAT, 32'h0);
    chk(rd[0] === 1'b1, "idle status");
    int_src <= 6'h04;
    apb(0, `UFL_ADDR_ISR_STAT, 32'h0);
    chk(rd[0] === 1'b0, "pending status");
    int_src <= 6'h00;
    apb(0, 12'h040, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_line();
    logic [7:0] v;
    for (int i = 0; i < 64; i++)
    begin
      v = 8'(i);
      apb(1, a_lc, 32'(v));
      apb(0, a_lc, 32'h0);
      chk(rd === 32'(v) && data_bits === v[1:0], "line readback");
      chk(parity_mode === (v[3] ? {1'b0, v[5:4]} + 3'h1 : 3'h0), "parity");
      chk(stop_mode === (!v[2] ? 2'h0 : (v[1:0] == 2'h0 ? 2'h1 : 2'h2)), "stop");
    end
    tx_ser <= 1'b0;
    repeat (2) @(posedge clk);
    chk(txd === 1'b0, "txd follows shifter");
    tx_ser <= 1'b1;
    apb(1, a_lc, 32'h40);
    repeat (2) @(posedge clk);
    chk(txd === 1'b0 && div_sel === 1'b0, "break");
    apb(1, a_lc, 32'h80);
    repeat (2) @(posedge clk);
    chk(txd === 1'b1 && div_sel === 1'b1, "divisor select");
    apb(1, a_lc, 32'h0);
    $display("test line done");
  endtask

  task automatic t_fifo();
    apb(1, a_fc, 32'h09);
    repeat (2) @(posedge clk);
    chk(fifo_en === 1'b1 && dma_mode === 1'b1, "enable dma");
    apb(0, a_fc, 32'h0);
    chk(rd === 32'h0, "write only");
    apb(1, a_fc, 32'h0);
    repeat (2) @(posedge clk);
    chk(fifo_en === 1'b0 && dma_mode === 1'b1, "disable only");
    apb(1, a_fc, 32'h01);
    repeat (2) @(posedge clk);
    chk(dma_mode === 1'b0, "dma mode 0");
    $display("test fifo done");
  endtask

  task automatic t_rx();
    int lv [12] = '{1, 4, 8, 14, 8, 16, 24, 28, 8, 16, 56, 60};
    for (int t = 0; t < 3; t++)
      for (int s = 0; s < 4; s++)
      begin
        apb(1, a_ft, {24'h0, 2'(t), 6'h0});
        apb(1, a_fc, {24'h0, 2'(s), 6'h03});
        pulse(4'h1, lv[t*4+s] - 1);
        chk(rx_int === 1'b0, "below level");
        pulse(4'h1, 1);
        chk(rx_int === 1'b1, "level reached");
      end
    apb(1, a_ft, 32'hC0);
    apb(1, `UFL_ADDR_RX_LEVEL, 32'h05);
    apb(1, a_fc, 32'hC3);
    pulse(4'h1, 4);
    chk(rx_int === 1'b0, "table d below");
    pulse(4'h1, 1);
    chk(rx_int === 1'b1, "table d reached");
    $display("test rx done");
  endtask

  task automatic t_tx();
    apb(1, `UFL_ADDR_ENH_FUNC, 32'h10);
    apb(1, a_ft, 32'h40);
    apb(1, a_fc, 32'h37);
    pulse(4'h4, 3);
    pulse(4'h8, 1);
    pulse(4'h1, 3);
    pulse(4'h2, 1);
    apb(0, a_ct, 32'h0);
    chk(rd === 32'h0002_0002, "counts");
    apb(1, a_fc, 32'h05);
    apb(0, a_ct, 32'h0);
    chk(rd === 32'h0000_0002, "tx reset only");
    apb(1, a_fc, 32'h03);
    apb(0, a_ct, 32'h0);
    chk(rd === 32'h0, "rx reset");
    apb(1, a_ft, 32'h0);
    pulse(4'h4, 2);
    apb(0, `UFL_ADDR_ISR_STAT, 32'h0);
    repeat (2) @(posedge clk);
    chk(tx_int === 1'b0, "tx above level");
    pulse(4'h8, 2);
    chk(tx_int === 1'b1, "tx below level");
    apb(0, `UFL_ADDR_ISR_STAT, 32'h0);
    repeat (2) @(posedge clk);
    chk(tx_int === 1'b0, "status read clears tx");
    $display("test tx done");
  endtask

  task automatic t_irq();
    apb(1, `UFL_ADDR_EVT_MASK, 32'h0);
    apb(1, a_ft, 32'h0);
    apb(1, a_fc, 32'h07);
    apb(0, `UFL_ADDR_EVT_STAT, 32'h0);
    pulse(4'h1, 1);
    chk(irq === 1'b0, "masked event");
    apb(1, `UFL_ADDR_EVT_MASK, 32'h03);
    repeat (2) @(posedge clk);
    chk(irq === 1'b1, "mask gates irq");
    apb(0, `UFL_ADDR_EVT_STAT, 32'h0);
    chk(rd[0] === 1'b1, "rx event");
    repeat (2) @(posedge clk);
    chk(irq === 1'b0, "read clears status");
    $display("test irq done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      end_sim();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_line();
    t_fifo();
    t_rx();
    t_tx();
    t_irq();
    end_sim();
  end
endmodule

//--- sim/ufl_ctrl_asserts.sv
`timescale 1ns/1ns
`include "ufl_params.svh"
module ufl_chk
  import ufl_pkg::*;
#(
  parameter int CW = 9
)
(
  input logic        CLK,
  input logic        ARST_N,
  input logic        PSEL,
  input logic        PENABLE,
  input logic        PWRITE,
  input logic [11:0] PADDR,
  input logic [31:0] PWDATA,
  input logic        RX_PUSH,
  input logic        RX_POP,
  input logic        TX_PUSH,
  input logic        TX_POP,
  input logic        TX_SER,
  input logic [5:0]  INT_SRC,
  input logic [31:0] PRDATA,
  input logic        PREADY,
  input logic        PSLVERR,
  input logic        IRQ,
  input logic        TXD,
  input logic        FIFO_EN,
  input logic        DMA_MODE,
  input logic        DIV_SEL,
  input logic [1:0]  DATA_BITS,
  input logic [1:0]  STOP_MODE,
  input logic [2:0]  PARITY_MODE,
  input logic        RX_INT,
  input logic        TX_INT
);
  // ----------------------------------------
  // Shadow of line control
  // ----------------------------------------
  // Register reads back only through a bus read, so track bus writes
  logic [7:0] lc_q;
  logic [7:0] lco_q;
  wire        acc = PSEL && PENABLE;

  // Writes land at the completing edge; format outputs lag one flop more
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      lc_q  <= 8'h00;
      lco_q <= 8'h00;
    end
    else
    begin
      if (acc && PREADY && PWRITE && PADDR == `UFL_ADDR_LINE_CTL)
        lc_q <= PWDATA[7:0];
      lco_q <= lc_q;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_access;
    PSEL && PENABLE;
  endsequence

  AST_PREADY_WAIT: assert property (s_setup ##1 s_access |=> PREADY)
    else $error("pready not one cycle after access");
  AST_PREADY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("pready longer than one cycle");
  AST_ERR_READY: assert property (PSLVERR |-> PREADY)
    else $error("pslverr without pready");
  AST_ISR_IDLE: assert property (
    PREADY && !PWRITE && PADDR == `UFL_ADDR_ISR_STAT |-> PRDATA[0] == ($past(INT_SRC) == 6'h00))
    else $error("idle status bit wrong");
  AST_FIFO_EN: assert property (
    acc && PREADY && PWRITE && PADDR == `UFL_ADDR_FIFO_CTL |-> ##2 FIFO_EN == $past(PWDATA[0], 2))
    else $error("fifo enable not written");
  AST_DIV_SEL: assert property (DIV_SEL == lco_q[7])
    else $error("divisor select wrong");
  AST_BREAK: assert property (lc_q[6] |=> !TXD)
    else $error("break not low");
  AST_PARITY: assert property (
    PARITY_MODE == (lco_q[3] ? {1'b0, lco_q[5:4]} + 3'h1 : 3'h0))
    else $error("parity mode wrong");
  AST_STOP: assert property (
    DATA_BITS == lco_q[1:0] &&
    STOP_MODE == (!lco_q[2] ? 2'h0 : (lco_q[1:0] == 2'h0 ? 2'h1 : 2'h2)))
    else $error("stop or length wrong");
endmodule

bind ufl_ctrl ufl_chk #(.CW(CW)) u_chk (
  .CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .RX_PUSH(RX_PUSH), .RX_POP(RX_POP), .TX_PUSH(TX_PUSH),
  .TX_POP(TX_POP), .TX_SER(TX_SER), .INT_SRC(INT_SRC), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .IRQ(IRQ), .TXD(TXD), .FIFO_EN(FIFO_EN), .DMA_MODE(DMA_MODE),
  .DIV_SEL(DIV_SEL), .DATA_BITS(DATA_BITS), .STOP_MODE(STOP_MODE),
  .PARITY_MODE(PARITY_MODE), .RX_INT(RX_INT), .TX_INT(TX_INT)
);
